// ---- hdl/caoa_circ_calc.sv ----
// Purpose: Post-modify index calculation with circular wrap
// Assumes: Index starts inside the buffer, modify magnitude below length
// Notes: Purely combinational, one wrap at most
`timescale 1ns/10ps
module caoa_circ_calc (
    caoa_addr_if.calc a
);
    logic [caoa_pkg::ADDR_W-1:0] sum;
    logic [caoa_pkg::ADDR_W-1:0] top;
    always_comb begin
        sum = a.index + a.modify;
        top = a.base + a.length;
        a.next_index = sum;
        // Zero length is forced linear: one bound test would always hold
        if (a.circular && (a.length != caoa_pkg::REG_RESET)) begin
            if (sum >= top) begin
                a.next_index = sum - a.length;
            end else if (sum < a.base) begin
                a.next_index = sum + a.length;
            end
        end
    end
endmodule

// ---- hdl/caoa_core.sv ----
// Purpose: Circular post-modify address unit and offset alignment buffer
// Assumes: Decode gives index number, unit, group and circular flag
// Notes: Two address units of four circular registers each
`timescale 1ns/10ps
// What this block does
// - Offset loads give one block an extra one-element shift, the other none.
// - Extra element is a short word or a normal word by variant.
// - X offset word: X shifted misalignment plus one word, Y misalignment.
// - Y offset word: Y shifted misalignment plus one word, X misalignment.
// - Short offset: chosen block gets one extra short word shift.
// - Misalignment from bits 2:0 short or 1:0 word; Old low, New high.
// - Word misalignment zero: plain gives Old, offset gives New0 over Old3:1.
// - Add modify; subtract length at or above top; add length below base.
// - Zero length gives plain linear post-modify.
// - Length counts 32-bit words in the paired length register.
// - Only index 0 to 3 are circular, each with own base and length.
// - Circular is post-modify only, index updated on each access.
// - Circular calculation only with the circular operator, else linear.
// - Address unit add and subtract may also wrap circularly.
// - Old index drives the address; modified index written back.
// - Access group bits select plain, short or offset variant.
// - Buffer holds one quad; result from held and current quad.
module caoa_core (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic access_valid,
    input wire logic arith_valid,
    input wire logic unit_sel,
    input wire logic [caoa_pkg::IDX_SEL_W-1:0] idx_sel,
    input wire logic [caoa_pkg::ADDR_W-1:0] modify_val,
    input wire logic circular_operator,
    input wire logic [2:0] access_group,
    input wire logic wr_en,
    input wire logic [1:0] wr_kind,
    input wire logic [caoa_pkg::ADDR_W-1:0] wr_data,
    input wire logic rd_valid,
    input wire logic [caoa_pkg::QUAD_W-1:0] rd_quad,
    output logic [caoa_pkg::ADDR_W-1:0] addr_out_ff,
    output logic addr_valid_ff,
    output logic [caoa_pkg::ADDR_W-1:0] arith_result_ff,
    output logic arith_done_ff,
    output logic [caoa_pkg::QUAD_W-1:0] x_quad_ff,
    output logic [caoa_pkg::QUAD_W-1:0] y_quad_ff,
    output logic load_done_ff
);
    localparam int NREG = 2 * caoa_pkg::NUM_CIRC;
    localparam int TOT_W = 2 * caoa_pkg::QUAD_W;

    logic [caoa_pkg::ADDR_W-1:0] index_ff [NREG];
    logic [caoa_pkg::ADDR_W-1:0] base_ff [NREG];
    logic [caoa_pkg::ADDR_W-1:0] length_ff [NREG];
    logic [caoa_pkg::ADDR_W-1:0] nxt_index [NREG];
    logic [caoa_pkg::ADDR_W-1:0] nxt_base [NREG];
    logic [caoa_pkg::ADDR_W-1:0] nxt_length [NREG];
    logic [caoa_pkg::ADDR_W-1:0] nxt_addr_out;
    logic nxt_addr_valid;
    logic [caoa_pkg::ADDR_W-1:0] nxt_arith_result;
    logic nxt_arith_done;

    logic [caoa_pkg::QUAD_W-1:0] held_ff;
    logic [caoa_pkg::QUAD_W-1:0] nxt_held;
    logic [caoa_pkg::ADDR_W-1:0] pend_addr_ff;
    logic [caoa_pkg::ADDR_W-1:0] nxt_pend_addr;
    caoa_pkg::caoa_group_e pend_group_ff;
    caoa_pkg::caoa_group_e nxt_pend_group;
    logic [caoa_pkg::QUAD_W-1:0] nxt_x_quad;
    logic [caoa_pkg::QUAD_W-1:0] nxt_y_quad;
    logic nxt_load_done;

    logic [2:0] sel;
    caoa_addr_if ca ();

    caoa_circ_calc u_calc (
        .a(ca)
    );

    // Shift a joined New:Old pair by a count of 16-bit elements
    function automatic logic [caoa_pkg::QUAD_W-1:0] align_quad(
        input logic [caoa_pkg::QUAD_W-1:0] held,
        input logic [caoa_pkg::QUAD_W-1:0] cur,
        input logic [3:0] shorts
    );
        logic [TOT_W-1:0] joined;
        logic [TOT_W-1:0] moved;
        joined = {cur, held};
        moved = joined >> (shorts * caoa_pkg::SHORT_W);
        return moved[caoa_pkg::QUAD_W-1:0];
    endfunction

    // Misalignment in short elements, offset element added when asked
    function automatic logic [3:0] shift_count(
        input logic [caoa_pkg::ADDR_W-1:0] addr,
        input logic short_mode,
        input logic extra
    );
        logic [3:0] cnt;
        if (short_mode) begin
            cnt = {1'b0, addr[caoa_pkg::SHORT_MIS_W-1:0]};
            if (extra) begin
                cnt = cnt + {1'b0, caoa_pkg::EXTRA_SHIFT};
            end
        end else begin
            cnt = {1'b0, addr[caoa_pkg::WORD_MIS_W-1:0], 1'b0};
            if (extra) begin
                cnt = cnt + {caoa_pkg::EXTRA_SHIFT, 1'b0};
            end
        end
        return cnt;
    endfunction

    assign sel = {unit_sel, idx_sel};

    // Calculator input: access or address unit arithmetic on selected index
    always_comb begin
        ca.index = index_ff[sel];
        ca.modify = modify_val;
        ca.base = base_ff[sel];
        ca.length = length_ff[sel];
        ca.circular = circular_operator;
    end

    // Address unit register state
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            nxt_index[i] = index_ff[i];
            nxt_base[i] = base_ff[i];
            nxt_length[i] = length_ff[i];
        end
        nxt_addr_out = addr_out_ff;
        nxt_addr_valid = 1'b0;
        nxt_arith_result = arith_result_ff;
        nxt_arith_done = 1'b0;
        if (wr_en) begin
            case (wr_kind)
                2'h0: nxt_index[sel] = wr_data;
                2'h1: nxt_base[sel] = wr_data;
                2'h2: nxt_length[sel] = wr_data;
                default: ;
            endcase
        end
        if (access_valid) begin
            nxt_addr_out = index_ff[sel];
            nxt_addr_valid = 1'b1;
            nxt_index[sel] = ca.next_index;
        end else if (arith_valid) begin
            nxt_arith_result = ca.next_index;
            nxt_arith_done = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < NREG; i++) begin
                index_ff[i] <= caoa_pkg::REG_RESET;
                base_ff[i] <= caoa_pkg::REG_RESET;
                length_ff[i] <= caoa_pkg::REG_RESET;
            end
            addr_out_ff <= caoa_pkg::REG_RESET;
            addr_valid_ff <= 1'b0;
            arith_result_ff <= caoa_pkg::REG_RESET;
            arith_done_ff <= 1'b0;
        end else if (clk_en) begin
            index_ff <= nxt_index;
            base_ff <= nxt_base;
            length_ff <= nxt_length;
            addr_out_ff <= nxt_addr_out;
            addr_valid_ff <= nxt_addr_valid;
            arith_result_ff <= nxt_arith_result;
            arith_done_ff <= nxt_arith_done;
        end
    end

    // Alignment buffer state
    always_comb begin
        logic [3:0] xs;
        logic [3:0] ys;
        logic short_mode;
        xs = 4'h0;
        ys = 4'h0;
        short_mode = 1'b0;
        nxt_held = held_ff;
        nxt_pend_addr = pend_addr_ff;
        nxt_pend_group = pend_group_ff;
        nxt_x_quad = x_quad_ff;
        nxt_y_quad = y_quad_ff;
        nxt_load_done = 1'b0;
        if (access_valid) begin
            nxt_pend_addr = index_ff[sel];
            case (access_group)
                3'h0: nxt_pend_group = caoa_pkg::CAOA_ALIGN_WORD;
                3'h1: nxt_pend_group = caoa_pkg::CAOA_ALIGN_SHORT;
                3'h2: nxt_pend_group = caoa_pkg::CAOA_X_OFF_WORD;
                3'h3: nxt_pend_group = caoa_pkg::CAOA_Y_OFF_WORD;
                3'h4: nxt_pend_group = caoa_pkg::CAOA_X_OFF_SHORT;
                3'h5: nxt_pend_group = caoa_pkg::CAOA_Y_OFF_SHORT;
                default: nxt_pend_group = caoa_pkg::CAOA_ALIGN_NONE;
            endcase
        end
        if (rd_valid) begin
            case (pend_group_ff)
                caoa_pkg::CAOA_ALIGN_WORD: begin
                    xs = shift_count(pend_addr_ff, 1'b0, 1'b0);
                    ys = xs;
                end
                caoa_pkg::CAOA_ALIGN_SHORT: begin
                    short_mode = 1'b1;
                    xs = shift_count(pend_addr_ff, 1'b1, 1'b0);
                    ys = xs;
                end
                caoa_pkg::CAOA_X_OFF_WORD: begin
                    xs = shift_count(pend_addr_ff, 1'b0, 1'b1);
                    ys = shift_count(pend_addr_ff, 1'b0, 1'b0);
                end
                caoa_pkg::CAOA_Y_OFF_WORD: begin
                    ys = shift_count(pend_addr_ff, 1'b0, 1'b1);
                    xs = shift_count(pend_addr_ff, 1'b0, 1'b0);
                end
                caoa_pkg::CAOA_X_OFF_SHORT: begin
                    short_mode = 1'b1;
                    xs = shift_count(pend_addr_ff, 1'b1, 1'b1);
                    ys = shift_count(pend_addr_ff, 1'b1, 1'b0);
                end
                caoa_pkg::CAOA_Y_OFF_SHORT: begin
                    short_mode = 1'b1;
                    ys = shift_count(pend_addr_ff, 1'b1, 1'b1);
                    xs = shift_count(pend_addr_ff, 1'b1, 1'b0);
                end
                default: begin
                    xs = 4'h0;
                    ys = 4'h0;
                end
            endcase
            // Word misalignment zero: Old whole, or New[0] over Old[3:1]
            nxt_x_quad = align_quad(held_ff, rd_quad, xs);
            nxt_y_quad = align_quad(held_ff, rd_quad, ys);
            nxt_held = rd_quad;
            nxt_load_done = (pend_group_ff != caoa_pkg::CAOA_ALIGN_NONE) | short_mode;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            held_ff <= caoa_pkg::QUAD_RESET;
            pend_addr_ff <= caoa_pkg::REG_RESET;
            pend_group_ff <= caoa_pkg::CAOA_ALIGN_NONE;
            x_quad_ff <= caoa_pkg::QUAD_RESET;
            y_quad_ff <= caoa_pkg::QUAD_RESET;
            load_done_ff <= 1'b0;
        end else if (clk_en) begin
            held_ff <= nxt_held;
            pend_addr_ff <= nxt_pend_addr;
            pend_group_ff <= nxt_pend_group;
            x_quad_ff <= nxt_x_quad;
            y_quad_ff <= nxt_y_quad;
            load_done_ff <= nxt_load_done;
        end
    end
endmodule

// ---- inc/caoa_addr_if.sv ----
// Purpose: Carries one circular index update request and its result
// Assumes: Single clock, combinational answer
// Notes: Used between caoa_core and the address calculator
`timescale 1ns/10ps
interface caoa_addr_if;
    logic [caoa_pkg::ADDR_W-1:0] index;
    logic [caoa_pkg::ADDR_W-1:0] modify;
    logic [caoa_pkg::ADDR_W-1:0] base;
    logic [caoa_pkg::ADDR_W-1:0] length;
    logic circular;
    logic [caoa_pkg::ADDR_W-1:0] next_index;
    modport calc (input index, modify, base, length, circular, output next_index);
    modport user (output index, modify, base, length, circular, input next_index);
endinterface

// ---- inc/caoa_pkg.sv ----
// Purpose: Shared constants and types for circular addressing and offset alignment
// Assumes: 32-bit addresses, quad word of four 32-bit words
// Notes: Access group codes are internal encodings of the decoded variant
package caoa_pkg;
    localparam int ADDR_W = 32;
    localparam int WORD_W = 32;
    localparam int QUAD_W = 128;
    localparam int SHORT_W = 16;
    localparam int NUM_CIRC = 4;
    localparam int IDX_SEL_W = 2;
    localparam int WORD_MIS_LSB = 0;
    localparam int WORD_MIS_W = 2;
    localparam int SHORT_MIS_W = 3;
    localparam int UNIT_SEL_W = 1;
    localparam logic [ADDR_W-1:0] REG_RESET = 32'h0000_0000;
    localparam logic [QUAD_W-1:0] QUAD_RESET = 128'h0;
    localparam logic [SHORT_MIS_W-1:0] EXTRA_SHIFT = 3'h1;

    typedef enum logic [2:0] {
        CAOA_ALIGN_WORD,
        CAOA_ALIGN_SHORT,
        CAOA_X_OFF_WORD,
        CAOA_Y_OFF_WORD,
        CAOA_X_OFF_SHORT,
        CAOA_Y_OFF_SHORT,
        CAOA_ALIGN_NONE
    } caoa_group_e;
endpackage

// ---- test/caoa_core_chk.sv ----
// Purpose: Port assertions for caoa_core
// Assumes: One clock, sync active-low reset
// Notes: Helper regs mirror held quad and last group
`timescale 1ns/10ps
module caoa_core_chk (
    input wire logic clock, rst_n, clk_en, access_valid, arith_valid, unit_sel,
    input wire logic [1:0] idx_sel,
    input wire logic [31:0] modify_val, addr_out_ff,
    input wire logic circular_operator, rd_valid, addr_valid_ff, arith_done_ff, load_done_ff,
    input wire logic [2:0] access_group,
    input wire logic [127:0] rd_quad, x_quad_ff, y_quad_ff
);
    logic [127:0] held_ff, nxt_held, ex, ey;
    logic [2:0] grp_ff, nxt_grp;
    logic [3:0] sh;
    always_comb begin
        nxt_held = (clk_en && rd_valid) ? rd_quad : held_ff;
        nxt_grp = (clk_en && access_valid) ? access_group : grp_ff;
        sh = (grp_ff inside {3'h1, 3'h4, 3'h5}) ? {1'b0, addr_out_ff[2:0]}
            : {1'b0, addr_out_ff[1:0], 1'b0};
        ex = 128'({rd_quad, held_ff} >> 16 * (sh + (grp_ff == 3'h2 ? 2 : grp_ff == 3'h4)));
        ey = 128'({rd_quad, held_ff} >> 16 * (sh + (grp_ff == 3'h3 ? 2 : grp_ff == 3'h5)));
    end
    always_ff @(posedge clock) begin
        held_ff <= rst_n ? nxt_held : 128'h0;
        grp_ff <= rst_n ? nxt_grp : 3'h6;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_lin; clk_en && access_valid && !circular_operator; endsequence
    sequence s_same; clk_en && access_valid && {unit_sel, idx_sel} == $past({unit_sel, idx_sel});
    endsequence
    AST_LINEAR: assert property (s_lin ##1 s_same |=>
        addr_out_ff == $past(addr_out_ff) + $past(modify_val, 2)) else $error("bad step");
    AST_LOAD: assert property (clk_en && rd_valid && grp_ff < 3'h6 |=>
        x_quad_ff == $past(ex) && y_quad_ff == $past(ey) && load_done_ff) else $error("bad load");
    AST_NO_LOAD: assert property (clk_en && rd_valid && grp_ff > 3'h5 |=> !load_done_ff)
        else $error("load without group");
    AST_ADDR: assert property (clk_en && access_valid |=> addr_valid_ff && !arith_done_ff)
        else $error("no address");
    AST_IDLE: assert property (clk_en && !access_valid |=> !addr_valid_ff && $stable(addr_out_ff))
        else $error("spurious address");
    AST_ARITH: assert property (clk_en && arith_valid && !access_valid |=> arith_done_ff)
        else $error("no arith result");
    AST_FREEZE: assert property (!clk_en |=> $stable(addr_out_ff) && $stable(x_quad_ff))
        else $error("moved while frozen");
    AST_NO_RD: assert property (clk_en && !rd_valid |=> !load_done_ff)
        else $error("done without data");
endmodule
bind caoa_core caoa_core_chk u_chk (.clock, .rst_n, .clk_en, .access_valid, .arith_valid,
    .unit_sel, .idx_sel, .modify_val, .addr_out_ff, .circular_operator, .rd_valid,
    .addr_valid_ff, .arith_done_ff, .load_done_ff, .access_group, .rd_quad, .x_quad_ff, .y_quad_ff);

// ---- test/caoa_mem_model.sv ----
// Purpose: Memory read path model
// Assumes: Quad k holds shorts 8k to 8k+7
// Notes: Idle data shows the inverse of the last quad
`timescale 1ns/10ps
module caoa_mem_model (
    input wire logic clock,
    input wire logic addr_valid,
    input wire logic [31:0] addr,
    input wire logic short_units,
    input wire logic slow,
    output logic rd_valid,
    output logic [127:0] rd_quad
);
    initial begin
        rd_valid = 1'b0;
        rd_quad = 128'h0;
    end
    always @(negedge clock) begin
        if (rd_valid) begin
            rd_valid <= 1'b0;
            rd_quad <= ~rd_quad;
        end
        if (addr_valid) begin
            if (slow)
                @(negedge clock);
            rd_valid <= 1'b1;
            for (int j = 0; j < 8; j++)
                rd_quad[16*j +: 16] <= 16'((short_units ? addr >> 3 : addr >> 2) * 8 + j);
        end
    end
endmodule

// ---- test/tb_circular_addr_and_offset_align.sv ----
// Purpose: Self-checking bench for caoa_core
// Assumes: Memory model answers each access a cycle later, two cycles later when slow
// Notes: Loads read two neighbouring quads
`timescale 1ns/10ps
module tb_circular_addr_and_offset_align;
    logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, access_valid = 1'b0, arith_valid = 1'b0;
    logic unit_sel = 1'b0, circular_operator = 1'b0, wr_en = 1'b0, short_units = 1'b0;
    logic slow = 1'b0, rd_valid, addr_valid_ff, arith_done_ff, load_done_ff;
    logic [1:0] idx_sel = 2'h0, wr_kind = 2'h0;
    logic [2:0] access_group = 3'h6;
    logic [31:0] modify_val = 32'h0, wr_data = 32'h0, addr_out_ff, arith_result_ff;
    logic [127:0] rd_quad, x_quad_ff, y_quad_ff;
    logic [31:0] m [3][8] = '{default: 32'h0};
    int failures = 0, tests_run = 0;
    always #2.5 clock = ~clock;
    caoa_core u_dut (.clock, .rst_n, .clk_en, .access_valid, .arith_valid, .unit_sel, .idx_sel,
        .modify_val, .circular_operator, .access_group, .wr_en, .wr_kind, .wr_data, .rd_valid,
        .rd_quad, .addr_out_ff, .addr_valid_ff, .arith_result_ff, .arith_done_ff, .x_quad_ff,
        .y_quad_ff, .load_done_ff);
    caoa_mem_model u_mem (.clock, .addr_valid(addr_valid_ff), .addr(addr_out_ff), .short_units,
        .slow, .rd_valid, .rd_quad);
    // Two neighbouring quads joined, then shifted down by s shorts
    function automatic logic [127:0] qd(input logic [31:0] q, input int s);
        logic [255:0] pair;
        pair = 256'h0;
        for (int j = 0; j < 16; j++)
            pair[16*j +: 16] = 16'(q * 8 + j);
        return 128'(pair >> 16 * s);
    endfunction
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int r, input logic [1:0] k, input logic [31:0] d);
        {unit_sel, idx_sel, wr_kind, wr_data} = {3'(r), k, d};
        {wr_en, access_valid, arith_valid} = 3'b100;
        @(negedge clock);
        if (k != 2'h3)
            m[k][r] = d;
    endtask
    task automatic acc(input int r, input logic [31:0] md, input logic c, input logic ar);
        logic [31:0] n;
        {unit_sel, idx_sel, modify_val, circular_operator} = {3'(r), md, c};
        {wr_en, access_valid, arith_valid} = {1'b0, !ar, ar};
        @(negedge clock);
        n = m[0][r] + md;
        if (c && m[2][r] != 0 && n >= m[1][r] + m[2][r])
            n -= m[2][r];
        else if (c && m[2][r] != 0 && n < m[1][r])
            n += m[2][r];
        if (ar)
            check(arith_result_ff, n);
        else
            check(addr_out_ff, m[0][r]);
        if (!ar)
            m[0][r] = n;
    endtask
    task automatic ld(input int r, input logic [2:0] g, input logic [31:0] a);
        logic sm;
        int b;
        sm = g inside {3'h1, 3'h4, 3'h5};
        b = sm ? int'(a[2:0]) : 2 * int'(a[1:0]);
        {short_units, access_group, slow} = {sm, g, a[0]};
        wr(r, 2'h0, a);
        repeat (2) begin
            acc(r, sm ? 32'h8 : 32'h4, 1'b0, 1'b0);
            {wr_en, access_valid, arith_valid} = 3'b000;
            for (int k = 0; k < 8 && load_done_ff !== 1'b1; k++)
                @(negedge clock);
            check(load_done_ff, 1'b1);
        end
        check(x_quad_ff, qd(sm ? a >> 3 : a >> 2, b + (g == 3'h2 ? 2 : g == 3'h4)));
        check(y_quad_ff, qd(sm ? a >> 3 : a >> 2, b + (g == 3'h3 ? 2 : g == 3'h5)));
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        for (int g = 0; g < 6; g++)
            for (int a = 0; a < (g inside {1, 4, 5} ? 8 : 4); a++)
                ld(g, 3'(g), 32'h100 + a);
        access_group = 3'h6;
        wr(0, 2'h1, 32'h100000);
        wr(0, 2'h2, 32'h0b);
        wr(0, 2'h0, 32'h100000);
        wr(7, 2'h1, 32'h200);
        wr(7, 2'h2, 32'h10);
        wr(7, 2'h0, 32'h201);
        wr(7, 2'h3, 32'h5);
        wr(1, 2'h1, 32'h50);
        for (int k = 0; k < 12; k++) begin
            acc(0, 32'h4, 1'b1, 1'b0);
            acc(7, 32'hffff_fffd, 1'b1, k[0]);
            acc(1, 32'h30, 1'b1, 1'b0);
        end
        acc(0, 32'h20, 1'b0, 1'b0);
        acc(0, 32'h4, 1'b0, 1'b0);
        {wr_en, access_valid, arith_valid} = 3'b000;
        @(negedge clock);
        {clk_en, access_valid} = 2'b01;
        repeat (3) @(negedge clock);
        {clk_en, access_valid} = 2'b10;
        @(negedge clock);
        acc(0, 32'h4, 1'b0, 1'b0);
        tally_and_finish();
    end
    initial begin
        #50000;
        failures++;
        tally_and_finish();
    end
endmodule
